// *** qps_pkg.sv ***
// shared constants for the quad pot two-wire slave and its master
package qps_pkg;
  localparam int QPS_CLK_HZ = 10_000_000;
  localparam logic [3:0] QPS_TYPE_ID = 4'h9; // device type identifier; value arbitrary
  localparam logic [3:0] QPS_OP_RD_WPR = 4'h9;
  localparam logic [3:0] QPS_OP_WR_WPR = 4'hA;
  localparam logic [3:0] QPS_OP_RD_DR = 4'hB;
  localparam logic [3:0] QPS_OP_WR_DR = 4'hC;
  localparam logic [3:0] QPS_OP_DR2W = 4'hD;
  localparam logic [3:0] QPS_OP_W2DR = 4'hE;
  localparam logic [3:0] QPS_OP_G_DR2W = 4'h1;
  localparam logic [3:0] QPS_OP_G_W2DR = 4'h8;
  localparam logic [3:0] QPS_OP_INCDEC = 4'h2;
  localparam int QPS_OP_MSB = 7; // opcode at bits 7..4
  localparam int QPS_POT_LSB = 2; // pot select at bits 3..2
  localparam int QPS_REG_LSB = 0; // register select at bits 1..0
  localparam int QPS_NV_WRITE_MS = 5; // typical write cycle
  localparam int QPS_NV_MAX_MS = 10; // longest write cycle
  localparam int QPS_NV_CYCLES = QPS_NV_WRITE_MS * (QPS_CLK_HZ / 1000);
  localparam int QPS_NV_MAX_CYCLES = QPS_NV_MAX_MS * (QPS_CLK_HZ / 1000);
  localparam int QPS_SCL_HALF = 4; // master divider half period in clocks
  localparam logic [7:0] QPS_WIPER_RST = 8'h00;
  localparam logic [7:0] QPS_DR_RST = 8'h00;
endpackage

// *** qps_if.sv ***
// two-wire bus between the pot slave and its master
`timescale 1ns/1ps
`default_nettype none
interface qps_if;
  logic scl_o; // master clock drive
  logic sda_m_o; // master data out
  logic sda_m_oe; // master pulls low when high
  logic sda_s_o; // slave data out
  logic sda_s_oe; // slave pulls low when high
  wire logic sda; // resolved open-drain level
  wire logic scl;
  assign scl = scl_o;
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (output scl_o, output sda_m_o, output sda_m_oe, input scl, input sda);
endinterface
`default_nettype wire

// *** qps_slave.sv ***
// quad digital pot two-wire slave: bus decode, wiper and data registers
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module qps_slave
  import qps_pkg::*;
#(
  parameter int NV_CYCLES = QPS_NV_CYCLES // internal write time
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  qps_if.slave bus,
  input wire logic [3:0] i_address_strap_inputs,
  output logic [255:0] o_wiper_onehot, // four pots, 64 switches each
  output logic [3:0] o_cascade_mode, // data bit 7 of each wiper register
  output logic o_nv_busy
);
  initial begin
    if (NV_CYCLES < 1 || NV_CYCLES > QPS_NV_MAX_CYCLES)
      $error("NV_CYCLES out of range");
  end
  // ----------------------------------------------------------------------
  // pin synchronisers: three stages, change once stages two and three agree
  // ----------------------------------------------------------------------
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic scl_q; // filtered clock level
  logic sda_q; // filtered data level
  logic scl_prev_q;
  logic sda_prev_q;
  logic [11:0] strap_sync_q; // three stages of the strap pins
  logic [3:0] strap_q; // filtered straps
  // sample pins every clock
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      strap_sync_q <= 12'h000;
      strap_q <= 4'h0;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], bus.scl};
      sda_sync_q <= {sda_sync_q[1:0], bus.sda};
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_q <= sda_sync_q[2];
      end
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
      strap_sync_q <= {strap_sync_q[7:0], i_address_strap_inputs};
      if (strap_sync_q[7:4] == strap_sync_q[11:8]) begin
        strap_q <= strap_sync_q[11:8];
      end
    end
  end
  // edge and condition decode
  wire scl_rise = scl_q && !scl_prev_q;
  wire scl_fall = !scl_q && scl_prev_q;
  // any data edge with clock high is a bus condition, never data
  wire start_det = scl_q && scl_prev_q && sda_prev_q && !sda_q;
  wire stop_det = scl_q && scl_prev_q && !sda_prev_q && sda_q;
  // ----------------------------------------------------------------------
  // protocol state machine
  // ----------------------------------------------------------------------
  typedef enum {ST_IDLE, ST_ADDR, ST_CMD, ST_DATA_RX, ST_DATA_TX, ST_INCDEC, ST_IGNORE}
    qps_state_type;
  qps_state_type state_q;
  logic [3:0] bit_cnt_q; // 0..7 data bits, 8 ack slot, F waits for the fall after start
  logic [7:0] shift_q;
  logic [7:0] instr_q; // last received instruction byte, acked or not
  logic ack_q; // slave pulling data low
  logic tx_q; // slave driving a read byte
  logic nv_pend_q; // nv write armed, fires on stop
  logic [31:0] nv_cnt_q;
  logic [7:0] wpr_q [4]; // wiper position registers
  logic [7:0] dr_q [16]; // data registers, index pot*4+reg
  logic init_q; // power-up load done
  wire [3:0] op = instr_q[QPS_OP_MSB -: 4];
  wire [1:0] pot = instr_q[QPS_POT_LSB +: 2];
  wire [1:0] rsel = instr_q[QPS_REG_LSB +: 2];
  wire [3:0] dr_idx = {pot, rsel};
  wire [7:0] rx_byte = {shift_q[6:0], sda_q};
  wire [3:0] rx_op = shift_q[7:4]; // whole byte already in shift_q at the fall
  wire addr_hit = (shift_q[7:4] == QPS_TYPE_ID) && (shift_q[3:0] == strap_q);
  wire rx_is_read = (rx_op == QPS_OP_RD_WPR) || (rx_op == QPS_OP_RD_DR);
  wire rx_is_3byte = rx_is_read || (rx_op == QPS_OP_WR_WPR) || (rx_op == QPS_OP_WR_DR);
  wire rx_known = rx_is_3byte || (rx_op == QPS_OP_DR2W) || (rx_op == QPS_OP_W2DR) ||
    (rx_op == QPS_OP_G_DR2W) || (rx_op == QPS_OP_G_W2DR) || (rx_op == QPS_OP_INCDEC);
  wire op_nv = (op == QPS_OP_WR_DR) || (op == QPS_OP_W2DR) || (op == QPS_OP_G_W2DR);
  wire [7:0] rd_val = (op == QPS_OP_RD_WPR) ? wpr_q[pot] : dr_q[dr_idx];
  wire busy = (nv_cnt_q != 32'h0);
  wire byte_end = scl_fall && (bit_cnt_q == 4'h7);
  wire ack_end = scl_fall && (bit_cnt_q == 4'h8);
  // bit-level sequencing on bus clock edges
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      instr_q <= 8'h00;
      ack_q <= 1'b0;
      tx_q <= 1'b0;
    end else if (start_det) begin
      // start restarts everything, even mid-byte; the fall after it is no bit
      state_q <= ST_ADDR;
      bit_cnt_q <= 4'hF;
      ack_q <= 1'b0;
      tx_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
      ack_q <= 1'b0;
      tx_q <= 1'b0;
    end else if (state_q == ST_INCDEC) begin
      // stepping handled in register block
    end else if (state_q != ST_IDLE && state_q != ST_IGNORE) begin
      if (scl_rise && bit_cnt_q < 4'h8 && !tx_q) begin // read bits move on the fall only
        shift_q <= rx_byte;
      end
      if (byte_end) begin
        bit_cnt_q <= 4'h8;
        tx_q <= 1'b0; // release after eighth bit
        case (state_q)
          ST_ADDR: ack_q <= addr_hit && !busy;
          ST_CMD: ack_q <= rx_known;
          ST_DATA_RX: ack_q <= 1'b1;
          default: ack_q <= 1'b0;
        endcase
        if (state_q == ST_CMD) begin
          instr_q <= shift_q;
        end
      end else if (scl_fall && bit_cnt_q == 4'hF) begin
        bit_cnt_q <= 4'h0;
      end else if (scl_fall && bit_cnt_q < 4'h7) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (tx_q) begin
          shift_q <= {shift_q[6:0], 1'b0};
        end
      end else if (ack_end) begin
        ack_q <= 1'b0;
        bit_cnt_q <= 4'h0;
        case (state_q)
          ST_ADDR: state_q <= ack_q ? ST_CMD : ST_IGNORE;
          ST_CMD: begin
            if (!ack_q) begin
              state_q <= ST_IGNORE;
            end else if (op == QPS_OP_INCDEC) begin
              state_q <= ST_INCDEC;
            end else if (op == QPS_OP_RD_WPR || op == QPS_OP_RD_DR) begin
              state_q <= ST_DATA_TX;
              tx_q <= 1'b1;
              shift_q <= rd_val;
            end else if (op == QPS_OP_WR_WPR || op == QPS_OP_WR_DR) begin
              state_q <= ST_DATA_RX;
            end else begin
              state_q <= ST_IGNORE; // two-byte command done, wait for stop
            end
          end
          ST_DATA_TX: begin
            // single data byte; further clocks are ignored
            state_q <= ST_IGNORE;
          end
          default: state_q <= ST_IGNORE;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------------
  // register file, transfers and nv write timer
  // ----------------------------------------------------------------------
  wire cmd_done = ack_end && state_q == ST_CMD && ack_q;
  wire data_done = ack_end && state_q == ST_DATA_RX && ack_q;
  wire step = scl_fall && state_q == ST_INCDEC; // whole pulses only, never a stop's rise
  // note: nv writes commit at the ack and the timer only gates the bus
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      init_q <= 1'b0;
      nv_pend_q <= 1'b0;
      nv_cnt_q <= 32'h0;
      for (int i = 0; i < 4; i++) wpr_q[i] <= QPS_WIPER_RST;
      for (int i = 0; i < 16; i++) dr_q[i] <= QPS_DR_RST;
    end else begin
      if (!init_q) begin
        init_q <= 1'b1;
        for (int i = 0; i < 4; i++) wpr_q[i] <= dr_q[i*4];
      end
      if (cmd_done) begin
        nv_pend_q <= op_nv;
        case (op)
          QPS_OP_DR2W: wpr_q[pot] <= dr_q[dr_idx];
          QPS_OP_W2DR: dr_q[dr_idx] <= wpr_q[pot];
          QPS_OP_G_DR2W: for (int i = 0; i < 4; i++) wpr_q[i] <= dr_q[i*4 + rsel];
          QPS_OP_G_W2DR: for (int i = 0; i < 4; i++) dr_q[i*4 + rsel] <= wpr_q[i];
          default: ;
        endcase
      end
      if (data_done) begin
        if (op == QPS_OP_WR_WPR) wpr_q[pot] <= shift_q;
        else dr_q[dr_idx] <= shift_q;
      end
      if (step) begin
        if (sda_q && wpr_q[pot][5:0] != 6'h3F) wpr_q[pot] <= wpr_q[pot] + 8'h01;
        else if (!sda_q && wpr_q[pot][5:0] != 6'h00) wpr_q[pot] <= wpr_q[pot] - 8'h01;
      end
      if (stop_det && nv_pend_q) begin
        nv_pend_q <= 1'b0;
        nv_cnt_q <= 32'(NV_CYCLES);
      end else if (start_det) begin
        nv_pend_q <= 1'b0;
      end else if (busy) begin
        nv_cnt_q <= nv_cnt_q - 32'h1;
      end
    end
  end
  // ----------------------------------------------------------------------
  // outputs: one-hot wiper decode per pot, pin drive from flops
  // ----------------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_pot
      // chaining of adjacent arrays is done outside using the cascade bit
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          o_wiper_onehot[gp*64 +: 64] <= 64'h1;
          o_cascade_mode[gp] <= 1'b0;
        end else begin
          o_wiper_onehot[gp*64 +: 64] <= 64'h1 << wpr_q[gp][5:0];
          o_cascade_mode[gp] <= wpr_q[gp][7];
        end
      end
    end
  endgenerate
  // data line: drive low for ack or a zero read bit, else released
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      bus.sda_s_o <= 1'b1;
      bus.sda_s_oe <= 1'b0;
      o_nv_busy <= 1'b0;
    end else begin
      bus.sda_s_o <= 1'b0;
      bus.sda_s_oe <= ack_q || (tx_q && bit_cnt_q < 4'h8 && !shift_q[7]);
      o_nv_busy <= busy; // inputs disabled while set
    end
  end
endmodule
`default_nettype wire

// *** qps_master.sv ***
// two-wire master that drives clock and sequences commands to the pot slave
`timescale 1ns/1ps
`default_nettype none
module qps_master
  import qps_pkg::*;
#(
  parameter int HALF = QPS_SCL_HALF // system clocks per clock half period
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  qps_if.master bus,
  input wire logic i_go, // one-cycle request
  input wire logic [7:0] i_addr, // slave address byte
  input wire logic [7:0] i_cmd, // instruction byte
  input wire logic [7:0] i_data, // data byte for writes
  input wire logic [1:0] i_nbytes, // bytes after address: 1 or 2
  input wire logic [7:0] i_steps, // inc/dec pulses, data level from i_data[0]
  output logic o_busy,
  output logic o_done, // one-cycle pulse
  output logic o_nack, // some byte not acked
  output logic [7:0] o_rdata
);
  initial begin
    if (HALF < 2) $error("HALF too small");
  end

  // ----------------------------------------------------------------------
  // sequencer: phases of a quarter-free half-period grid
  // ----------------------------------------------------------------------
  typedef enum {M_IDLE, M_START, M_BIT, M_STEP, M_STOP} qps_mstate_type;
  qps_mstate_type st_q;
  logic [15:0] div_q; // half-period divider
  logic ph_q; // 0: clock low half, 1: clock high half
  logic [3:0] bit_q; // 0..8, 8 is ack slot
  logic [1:0] byte_q; // byte index, 0 is address
  logic [7:0] sh_q;
  logic [7:0] steps_q;
  logic [7:0] cmd_q;
  logic [7:0] data_q;
  logic [1:0] nb_q;
  wire tick = (div_q == 16'(HALF - 1));
  wire rd = (cmd_q[7:4] == QPS_OP_RD_WPR) || (cmd_q[7:4] == QPS_OP_RD_DR);
  wire incdec = (cmd_q[7:4] == QPS_OP_INCDEC);
  wire last_byte = (byte_q == nb_q);

  // master alone makes the clock and starts every transfer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_q <= M_IDLE;
      div_q <= 16'h0;
      ph_q <= 1'b1;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      sh_q <= 8'h00;
      steps_q <= 8'h00;
      cmd_q <= 8'h00;
      data_q <= 8'h00;
      nb_q <= 2'h1;
      bus.scl_o <= 1'b1;
      bus.sda_m_o <= 1'b0;
      bus.sda_m_oe <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_nack <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      o_done <= 1'b0;
      div_q <= tick ? 16'h0 : div_q + 16'h1;
      case (st_q)
        M_IDLE: begin
          div_q <= 16'h0;
          if (i_go) begin
            st_q <= M_START;
            sh_q <= i_addr;
            cmd_q <= i_cmd;
            data_q <= i_data;
            nb_q <= i_nbytes;
            steps_q <= i_steps;
            byte_q <= 2'h0;
            bit_q <= 4'h0;
            o_busy <= 1'b1;
            o_nack <= 1'b0;
          end
        end
        M_START: if (tick) begin
          // data falls while clock high, then clock goes low
          if (!bus.sda_m_oe) bus.sda_m_oe <= 1'b1;
          else begin
            bus.scl_o <= 1'b0;
            ph_q <= 1'b0;
            st_q <= M_BIT;
          end
        end
        M_BIT: begin
          // data moves one clock into the low half, never with a clock edge
          if (!ph_q && div_q == 16'h0) begin
            bus.sda_m_oe <= (bit_q < 4'h8) && !sh_q[7] && !(byte_q == 2'h2 && rd);
          end
          if (tick && !ph_q) begin
            bus.scl_o <= 1'b1;
            ph_q <= 1'b1;
          end else if (tick) begin
            bus.scl_o <= 1'b0;
            ph_q <= 1'b0;
            if (bit_q < 4'h8) begin
              sh_q <= {sh_q[6:0], bus.sda};
              bit_q <= bit_q + 4'h1;
            end else begin
              // slave ack is data low on the ninth pulse
              if (bus.sda && !(rd && byte_q == nb_q && byte_q != 2'h0)) o_nack <= 1'b1;
              if (rd && byte_q == nb_q && byte_q != 2'h0) o_rdata <= sh_q;
              bit_q <= 4'h0;
              if (bus.sda && byte_q == 2'h0) st_q <= M_STOP; // polling miss
              else if (last_byte) st_q <= (incdec && steps_q != 8'h00) ? M_STEP : M_STOP;
              else begin
                byte_q <= byte_q + 2'h1;
                sh_q <= (byte_q == 2'h0) ? cmd_q : data_q;
              end
            end
          end
        end
        M_STEP: begin
          // one clock pulse per step, data level sets direction
          if (!ph_q && div_q == 16'h0) begin
            bus.sda_m_oe <= !data_q[0];
          end
          if (tick && !ph_q) begin
            bus.scl_o <= 1'b1;
            ph_q <= 1'b1;
          end else if (tick) begin
            bus.scl_o <= 1'b0;
            ph_q <= 1'b0;
            steps_q <= steps_q - 8'h01;
            if (steps_q == 8'h01) st_q <= M_STOP;
          end
        end
        M_STOP: if (tick) begin
          // data low, clock high, then data rises with clock high
          if (!ph_q) begin
            bus.sda_m_oe <= 1'b1;
            ph_q <= 1'b1;
          end else if (!bus.scl_o) begin
            bus.scl_o <= 1'b1;
          end else begin
            bus.sda_m_oe <= 1'b0;
            st_q <= M_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** qps_monitor.sv ***
// concurrent checks on the two-wire link between pot slave and master
`timescale 1ns/1ps
`default_nettype none
module qps_monitor
  import qps_pkg::*;
#(
  parameter int NV_CYCLES = QPS_NV_CYCLES // write cycle length in clocks
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic [3:0] i_address_strap_inputs,
  input wire logic o_nv_busy,
  input wire logic [255:0] o_wiper_onehot
);
  // ----------------------------------------
  // raw line decode
  // ----------------------------------------
  logic scl_q; // clock level one cycle ago
  logic sda_q; // data level one cycle ago
  logic first_q; // inside the address byte
  logic started_q; // a start seen since reset
  logic mism_q; // address named another device
  logic ok_q; // pulse: address matched while idle
  logic [3:0] bit_q; // address bits taken
  logic [6:0] sh_q; // address bits so far, msb first
  logic [3:0] stop_age_q; // clocks since stop, saturating
  logic [15:0] busy_cnt_q; // clocks spent in the write cycle
  wire logic scl_rise = scl && !scl_q;
  wire logic start_w = scl && scl_q && sda_q && !sda;
  wire logic stop_w = scl && scl_q && !sda_q && sda;
  wire logic last_w = scl_rise && first_q && (bit_q == 4'h7);
  wire logic match_w = ({sh_q, sda} == {QPS_TYPE_ID, i_address_strap_inputs});
  // line history; raw lines are seen without the slave's sync delay
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      stop_age_q <= 4'hF;
      busy_cnt_q <= 16'h0000;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      stop_age_q <= stop_w ? 4'h0 : stop_age_q + {3'h0, stop_age_q != 4'hF};
      busy_cnt_q <= o_nv_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
    end
  end
  // address byte tracker, restarted by every start
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      {first_q, started_q, mism_q, ok_q} <= 4'h0;
      bit_q <= 4'h0;
      sh_q <= 7'h00;
    end else begin
      ok_q <= last_w && match_w && !o_nv_busy;
      if (start_w) begin
        {first_q, started_q, mism_q} <= 3'h6;
        bit_q <= 4'h0;
      end else if (scl_rise && first_q) begin
        sh_q <= {sh_q[5:0], sda};
        bit_q <= bit_q + 4'h1;
        first_q <= !last_w;
        mism_q <= last_w && !match_w;
      end
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  property p_open_drain; sda_s_oe |-> !sda_s_o; endproperty
  property p_chg_low; $changed(sda_s_oe) |-> !scl; endproperty
  property p_ack_hold; $rose(sda_s_oe) |-> sda_s_oe [*8]; endproperty
  property p_no_start; !started_q |-> !sda_s_oe; endproperty
  property p_mismatch; mism_q |-> !sda_s_oe; endproperty
  property p_addr_ack; ok_q |-> ##[1:24] sda_s_oe; endproperty
  property p_busy_quiet; o_nv_busy |-> !sda_s_oe; endproperty
  property p_busy_stop; $rose(o_nv_busy) |-> stop_age_q <= 4'hA; endproperty
  property p_busy_len;
    $fell(o_nv_busy) |-> busy_cnt_q >= NV_CYCLES - 1 && busy_cnt_q <= NV_CYCLES + 1;
  endproperty
  property p_onehot;
    $onehot(o_wiper_onehot[63:0]) && $onehot(o_wiper_onehot[127:64])
      && $onehot(o_wiper_onehot[191:128]) && $onehot(o_wiper_onehot[255:192]);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("slave drove data high");
  a_chg_low: assert property (p_chg_low) else $error("slave data moved in clock high");
  a_ack_hold: assert property (p_ack_hold) else $error("slave low too short");
  a_no_start: assert property (p_no_start) else $error("slave drove before start");
  a_mismatch: assert property (p_mismatch) else $error("foreign address acked");
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
  a_busy_quiet: assert property (p_busy_quiet) else $error("acked while writing");
  a_busy_stop: assert property (p_busy_stop) else $error("write began without stop");
  a_busy_len: assert property (p_busy_len) else $error("write cycle length off");
  a_onehot: assert property (p_onehot) else $error("wiper switch not one-hot");
  c_ack: cover property (ok_q);
  c_refuse: cover property (mism_q);
  c_write: cover property ($rose(o_nv_busy));
endmodule
`default_nettype wire

// *** quad_pot_serial_slave_tb.sv ***
// self-checking bench: pot slave and master joined on one link
`timescale 1ns/1ps
`default_nettype none
module quad_pot_serial_slave_tb;
  import qps_pkg::*;
  // ----------------------------------------
  // set-up
  // ----------------------------------------
  localparam int NV = 600; // write cycle kept longer than a poll frame
  localparam logic [7:0] ADR = {QPS_TYPE_ID, 4'hA}; // strap value arbitrary
  localparam logic [7:0] WV [4] = '{8'h05, 8'h3F, 8'h92, 8'h20}; // wiper values
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic go = 1'b0;
  logic [7:0] a = 8'h00, c = 8'h00, d = 8'h00, steps = 8'h00;
  logic [1:0] nb = 2'h1;
  logic [3:0] straps = 4'hA;
  wire logic done, nack, nvb;
  wire logic [7:0] rdata;
  wire logic [3:0] casc;
  wire logic [255:0] wiper;
  int n_mismatch = 0, tests_run = 0, cycles = 0, p;
  always #50 i_sys_clk = !i_sys_clk;
  qps_if i_qps_if ();
  // link half period widened to cover the slave's pin sync delay
  qps_master #(.HALF(8)) i_qps_master (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .bus(i_qps_if), .i_go(go), .i_addr(a), .i_cmd(c), .i_data(d), .i_nbytes(nb),
    .i_steps(steps), .o_busy(), .o_done(done), .o_nack(nack), .o_rdata(rdata));
  qps_slave #(.NV_CYCLES(NV)) i_qps_slave (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .bus(i_qps_if), .i_address_strap_inputs(straps), .o_wiper_onehot(wiper),
    .o_cascade_mode(casc), .o_nv_busy(nvb));
  qps_monitor #(.NV_CYCLES(NV)) i_qps_monitor (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .scl(i_qps_if.scl), .sda(i_qps_if.sda),
    .sda_s_o(i_qps_if.sda_s_o), .sda_s_oe(i_qps_if.sda_s_oe),
    .i_address_strap_inputs(straps), .o_nv_busy(nvb), .o_wiper_onehot(wiper));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string s);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  // wiper position seen as one switch of the pot's 64
  task automatic chk_pos(input int pot, input logic [5:0] pos);
    chk(wiper[pot*64 +: 64], 64'h1 << pos, "wiper switch");
  endtask
  // one master frame, inputs launched on the falling edge
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, input logic [1:0] n,
                      input logic [7:0] st, input logic [7:0] adr = ADR);
    int k;
    @(negedge i_sys_clk);
    {a, c, d, nb, steps, go} = {adr, cmd, dat, n, st, 1'b1};
    @(negedge i_sys_clk);
    go = 1'b0;
    for (k = 0; k < 4000 && done !== 1'b1; k++) @(negedge i_sys_clk);
    chk(done, 1'b1, "frame done");
  endtask
  // bounded wait for the internal write to finish
  task automatic wait_idle();
    int k;
    repeat (10) @(negedge i_sys_clk); // busy rises a few clocks after the stop
    for (k = 0; k < 2000 && nvb !== 1'b0; k++) @(negedge i_sys_clk);
    chk(nvb, 1'b0, "write cycle end");
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, about four times the expected run
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    repeat (8) @(negedge i_sys_clk);
    for (p = 0; p < 4; p++) chk_pos(p, 6'h00);
    fin("reset");
    for (p = 0; p < 4; p++) begin
      xfer({QPS_OP_WR_WPR, p[1:0], 2'h0}, WV[p], 2'h2, 8'h00);
      chk(nack, 1'b0, "wiper write ack");
      chk_pos(p, WV[p][5:0]);
      chk(casc[p], WV[p][7], "cascade bit");
      xfer({QPS_OP_RD_WPR, p[1:0], 2'h0}, 8'h00, 2'h2, 8'h00);
      chk(rdata, WV[p], "wiper read");
    end
    fin("wiper");
    xfer({QPS_OP_WR_WPR, 4'h0}, 8'h11, 2'h2, 8'h00, {QPS_TYPE_ID, 4'h5});
    chk(nack, 1'b1, "strap mismatch");
    xfer({QPS_OP_WR_WPR, 4'h0}, 8'h11, 2'h2, 8'h00, {4'h3, 4'hA});
    chk(nack, 1'b1, "type mismatch");
    chk_pos(0, WV[0][5:0]);
    fin("address");
    xfer({QPS_OP_WR_DR, 2'h1, 2'h2}, 8'h2A, 2'h2, 8'h00);
    chk(nack, 1'b0, "data write ack");
    repeat (10) @(negedge i_sys_clk);
    chk(nvb, 1'b1, "write cycle start");
    xfer({QPS_OP_RD_DR, 2'h1, 2'h2}, 8'h00, 2'h2, 8'h00);
    chk(nack, 1'b1, "poll while busy");
    wait_idle();
    xfer({QPS_OP_RD_DR, 2'h1, 2'h2}, 8'h00, 2'h2, 8'h00);
    chk(rdata, 8'h2A, "data read");
    fin("nv write");
    xfer({QPS_OP_DR2W, 2'h1, 2'h2}, 8'h00, 2'h1, 8'h00);
    chk_pos(1, 6'h2A);
    xfer({QPS_OP_W2DR, 2'h0, 2'h3}, 8'h00, 2'h1, 8'h00);
    wait_idle();
    xfer({QPS_OP_RD_DR, 2'h0, 2'h3}, 8'h00, 2'h2, 8'h00);
    chk(rdata, WV[0], "wiper to data");
    xfer({QPS_OP_G_W2DR, 4'h1}, 8'h00, 2'h1, 8'h00);
    wait_idle();
    xfer({QPS_OP_RD_DR, 2'h3, 2'h1}, 8'h00, 2'h2, 8'h00);
    chk(rdata, WV[3], "global wiper to data");
    xfer({QPS_OP_G_DR2W, 4'h0}, 8'h00, 2'h1, 8'h00);
    for (p = 0; p < 4; p++) chk_pos(p, 6'h00);
    chk(casc, 4'h0, "cascade cleared");
    fin("transfers");
    xfer({QPS_OP_WR_WPR, 2'h3, 2'h0}, 8'h3E, 2'h2, 8'h00);
    xfer({QPS_OP_INCDEC, 2'h3, 2'h0}, 8'h01, 2'h1, 8'h03);
    chk_pos(3, 6'h3F);
    xfer({QPS_OP_INCDEC, 2'h3, 2'h0}, 8'h00, 2'h1, 8'h05);
    chk_pos(3, 6'h3A);
    xfer({4'h3, 4'h0}, 8'h00, 2'h1, 8'h00);
    chk(nack, 1'b1, "unknown opcode");
    fin("step");
    end_of_test();
  end
endmodule
`default_nettype wire
